// [verilog/gauge_pkg.sv]
// Constants shared by the charge gauge pin and register logic.
// Assumes a 100 MHz system clock and 32-bit AXI4-Lite register access.
package gauge_pkg;
  // System clock and pin timing
  localparam int CLK_MHZ              = 100;
  localparam int CHARGE_DONE_MIN_NS   = 1000;  // Least charge-done high time
  localparam int CHARGE_DONE_MIN_CYC  = (CHARGE_DONE_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int SCL_MAX_KHZ          = 400;   // Guaranteed serial clock rate
  localparam int SCL_MIN_HALF_CYC     = (CLK_MHZ * 1000) / (2 * SCL_MAX_KHZ);
  // AXI byte offsets
  localparam logic [7:0] OFS_STATUS   = 8'h00;
  localparam logic [7:0] OFS_CONTROL  = 8'h04;
  localparam logic [7:0] OFS_CHARGE   = 8'h08;
  localparam logic [7:0] OFS_THR_HIGH = 8'h0C;
  localparam logic [7:0] OFS_THR_LOW  = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  // Reset values
  localparam logic [7:0]  CONTROL_RST  = 8'h3C;
  localparam logic [15:0] CHARGE_RST   = 16'h7FFF;
  localparam logic [15:0] THR_HIGH_RST = 16'hFFFF;
  localparam logic [15:0] THR_LOW_RST  = 16'h0000;
  localparam logic [15:0] CHARGE_FULL  = 16'hFFFF;
  localparam logic [15:0] CHARGE_EMPTY = 16'h0000;
  localparam logic [4:0]  IRQ_MASK_RST = 5'h00;
  // Control field positions
  localparam int CTL_VBAT_LSB  = 6;  // [7:6] battery alert level select
  localparam int CTL_PRESC_LSB = 3;  // [5:3] prescale exponent, M = 2**code
  localparam int CTL_PIN_LSB   = 1;  // [2:1] shared pin function
  localparam int CTL_SHUTDOWN  = 0;  // [0] stop counting
  // Battery alert level codes
  localparam logic [1:0] VBAT_2V8 = 2'h1;
  localparam logic [1:0] VBAT_2V9 = 2'h2;
  localparam logic [1:0] VBAT_3V0 = 2'h3;
  // Shared pin function codes
  localparam logic [1:0] PIN_ALERT       = 2'h2;
  localparam logic [1:0] PIN_CHARGE_DONE = 2'h1;
  // Status bit positions
  localparam int ST_ID   = 7;
  localparam int ST_OVF  = 5;
  localparam int ST_HIGH = 3;
  localparam int ST_LOW  = 2;
  localparam int ST_VBAT = 1;
  localparam int ST_UVLO = 0;
  // Interrupt bit positions
  localparam int IRQ_HIGH = 0;
  localparam int IRQ_LOW  = 1;
  localparam int IRQ_OVF  = 2;
  localparam int IRQ_VBAT = 3;
  localparam int IRQ_DONE = 4;
  // Serial bus
  localparam logic [6:0] SERIAL_ADDR = 7'h4A;  // Arbitrary bus address
  localparam logic [1:0] AXI_OKAY    = 2'h0;
  localparam logic [1:0] AXI_SLVERR  = 2'h2;
endpackage : gauge_pkg

// [verilog/pin_sync.sv]
// Two-flop synchroniser for a group of asynchronous levels.
// Assumes each bit is independent; no bus coherence is kept.
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] async_in,
  input  wire logic [W-1:0] rst_val,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r   <= rst_val;  // Idle level of each pin, so no false edge follows reset
      sync_out <= rst_val;
    end else if (ce) begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule : pin_sync

// [verilog/gauge_pin_top.sv]
// Charge gauge digital core: counter, limits, shared alert/charge-done pin,
// serial slave and AXI4-Lite register slave.
// Assumes pins and analog events are asynchronous and the host keeps one access outstanding.
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module gauge_pin_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        ramp_flip,
  input  wire logic        ramp_up,
  input  wire logic        vbat_below_2v8,
  input  wire logic        vbat_below_2v9,
  input  wire logic        vbat_below_3v0,
  input  wire logic        uvlo_seen,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  input  wire logic        alert_or_charge_done_pin_in,
  output logic             alert_or_charge_done_pin_out,
  output logic             alert_or_charge_done_pin_oe_n,
  output logic             irq
);
  typedef enum logic [6:0] {
    SER_IDLE   = 7'b000_0001,
    SER_ADDR   = 7'b000_0010,
    SER_ACK_A  = 7'b000_0100,
    SER_WR     = 7'b000_1000,
    SER_ACK_W  = 7'b001_0000,
    SER_RD     = 7'b010_0000,
    SER_ACK_R  = 7'b100_0000
  } ser_state_t;

  localparam logic [7:0] CHIP_ID_BIT = 8'h80;  // Arbitrary identification bit value

  logic        flip_q, flip_d_r, up_q, v28_q, v29_q, v30_q, uvlo_q, scl_q, sda_q, pin_q;
  logic        scl_d_r, sda_d_r;
  logic [7:0]  control_r;
  logic [15:0] charge_r, thr_high_r, thr_low_r;
  logic [6:0]  presc_r;
  logic [5:0]  flags_r;        // {ovf, high, low, vbat} at bits 3..0 plus uvlo, spare
  logic [4:0]  irq_stat_r, irq_mask_r;
  logic [5:0]  flags_prev_r;
  logic        aw_held_r, w_held_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  ser_state_t  ser_r;
  logic [3:0]  bit_cnt_r;
  logic [7:0]  shift_r;
  logic [2:0]  ptr_r;
  logic        ptr_done_r, rw_r, wr_data_ok_r, wr_data_ok;

  // Asynchronous pins and analog events pass two flops first
  pin_sync #(.W(9)) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .async_in ({ramp_flip, ramp_up, vbat_below_2v8, vbat_below_2v9, vbat_below_3v0,
                uvlo_seen, scl_in, sda_in, alert_or_charge_done_pin_in}),
    .rst_val  (9'h007),  // Serial clock, data and shared pin idle high
    .sync_out ({flip_q, up_q, v28_q, v29_q, v30_q, uvlo_q, scl_q, sda_q, pin_q})
  );

  // Decoded controls
  logic [1:0] pin_mode;
  logic [1:0] vbat_sel;
  logic [2:0] presc_code;
  logic       alert_mode, done_mode, counting;
  assign pin_mode   = control_r[gauge_pkg::CTL_PIN_LSB+:2];
  assign vbat_sel   = control_r[gauge_pkg::CTL_VBAT_LSB+:2];
  assign presc_code = control_r[gauge_pkg::CTL_PRESC_LSB+:3];
  assign alert_mode = (pin_mode == gauge_pkg::PIN_ALERT);
  assign done_mode  = (pin_mode == gauge_pkg::PIN_CHARGE_DONE);
  assign counting   = !control_r[gauge_pkg::CTL_SHUTDOWN];

  // Prescale top value: M - 1 with M = 2**code, so one count weighs M/128
  function automatic logic [6:0] presc_top(input logic [2:0] code);
    presc_top = 7'((8'h01 << code) - 8'h01);
  endfunction : presc_top

  // Selected battery comparator level
  logic vbat_low;
  always_comb begin
    case (vbat_sel)
      gauge_pkg::VBAT_2V8: vbat_low = v28_q;
      gauge_pkg::VBAT_2V9: vbat_low = v29_q;
      gauge_pkg::VBAT_3V0: vbat_low = v30_q;
      default:             vbat_low = 1'b0;
    endcase
  end

  // Serial and AXI write/read events toward the register file
  logic       ser_wr, ser_rd_status, axi_wr, axi_rd_status;
  logic [7:0] axi_wa;
  logic [31:0] axi_wd;
  logic [3:0]  axi_ws;
  logic        charge_load;
  assign charge_load = done_mode && pin_q;

  // Strobe merge of a byte-laned write
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[8*i+:8] = strb[i] ? new_v[8*i+:8] : old_v[8*i+:8];
    end
  endfunction : merge

  // Ramp reversal edge
  logic flip_ev;
  assign flip_ev = flip_q && !flip_d_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flip_d_r <= 1'b0;
      scl_d_r  <= 1'b1;
      sda_d_r  <= 1'b1;
    end else if (ce) begin
      flip_d_r <= flip_q;
      scl_d_r  <= scl_q;
      sda_d_r  <= sda_q;
    end
  end

  // Prescaler and saturating accumulator
  logic carry_up, carry_dn;
  assign carry_up = counting && flip_ev && up_q && (presc_r == presc_top(presc_code));
  assign carry_dn = counting && flip_ev && !up_q && (presc_r == 7'h00);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_r <= 7'h00;
    end else if (ce) begin
      if (counting && flip_ev) begin
        if (up_q) begin
          presc_r <= carry_up ? 7'h00 : 7'(presc_r + 7'h01);
        end else begin
          presc_r <= carry_dn ? presc_top(presc_code) : 7'(presc_r - 7'h01);
        end
      end
    end
  end

  // Serial write path lands in byte view
  logic [7:0] ser_wbyte;
  logic [2:0] ser_wptr;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      charge_r <= gauge_pkg::CHARGE_RST;
    end else if (ce) begin
      if (charge_load) begin
        charge_r <= gauge_pkg::CHARGE_FULL;
      end else if (axi_wr && axi_wa == gauge_pkg::OFS_CHARGE) begin
        charge_r <= 16'(merge({16'h0000, charge_r}, axi_wd, axi_ws));
      end else if (ser_wr && ser_wptr == 3'h2) begin
        charge_r <= {ser_wbyte, charge_r[7:0]};
      end else if (ser_wr && ser_wptr == 3'h3) begin
        charge_r <= {charge_r[15:8], ser_wbyte};
      end else if (carry_up && charge_r != gauge_pkg::CHARGE_FULL) begin
        charge_r <= 16'(charge_r + 16'h0001);
      end else if (carry_dn && charge_r != gauge_pkg::CHARGE_EMPTY) begin
        charge_r <= 16'(charge_r - 16'h0001);
      end
    end
  end

  // Control and limits, AXI wins over a same-cycle serial write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_r  <= gauge_pkg::CONTROL_RST;
      thr_high_r <= gauge_pkg::THR_HIGH_RST;
      thr_low_r  <= gauge_pkg::THR_LOW_RST;
      irq_mask_r <= gauge_pkg::IRQ_MASK_RST;
    end else if (ce) begin
      if (axi_wr) begin
        if (axi_wa == gauge_pkg::OFS_CONTROL) control_r <= 8'(merge(32'h0, axi_wd, axi_ws));
        if (axi_wa == gauge_pkg::OFS_THR_HIGH) begin
          thr_high_r <= 16'(merge({16'h0000, thr_high_r}, axi_wd, axi_ws));
        end
        if (axi_wa == gauge_pkg::OFS_THR_LOW) begin
          thr_low_r <= 16'(merge({16'h0000, thr_low_r}, axi_wd, axi_ws));
        end
        if (axi_wa == gauge_pkg::OFS_IRQ_MASK && axi_ws[0]) irq_mask_r <= axi_wd[4:0];
      end else if (ser_wr) begin
        case (ser_wptr)
          3'h1:    control_r  <= ser_wbyte;
          3'h4:    thr_high_r <= {ser_wbyte, thr_high_r[7:0]};
          3'h5:    thr_high_r <= {thr_high_r[15:8], ser_wbyte};
          3'h6:    thr_low_r  <= {ser_wbyte, thr_low_r[7:0]};
          3'h7:    thr_low_r  <= {thr_low_r[15:8], ser_wbyte};
          default: control_r  <= control_r;
        endcase
      end
    end
  end

  // Live conditions behind each status flag
  logic [5:0] cond;
  assign cond = {1'b0, uvlo_q,
                 (charge_r == gauge_pkg::CHARGE_FULL) || (charge_r == gauge_pkg::CHARGE_EMPTY),
                 charge_r > thr_high_r, charge_r < thr_low_r, vbat_low};

  // Flags set by condition, cleared by a status read once gone; set wins
  logic rd_clr;
  assign rd_clr = ser_rd_status || axi_rd_status;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_r      <= 6'h00;
      flags_prev_r <= 6'h00;
    end else if (ce) begin
      flags_r      <= cond | (rd_clr ? 6'h00 : flags_r);
      flags_prev_r <= flags_r;
    end
  end

  // Status byte in the device's layout
  logic [7:0] status_byte;
  assign status_byte = CHIP_ID_BIT | {2'b00, flags_r[3], 1'b0, flags_r[2], flags_r[1],
                                      flags_r[0], flags_r[4]};

  // Sticky interrupt status, write one to clear, new event wins
  logic [4:0] irq_ev, irq_w1c;
  assign irq_ev  = {charge_load, flags_r[0] && !flags_prev_r[0], flags_r[3] && !flags_prev_r[3],
                    flags_r[1] && !flags_prev_r[1], flags_r[2] && !flags_prev_r[2]};
  assign irq_w1c = (axi_wr && axi_wa == gauge_pkg::OFS_IRQ_STAT && axi_ws[0]) ? axi_wd[4:0]
                                                                           : 5'h00;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= 5'h00;
    end else if (ce) begin
      irq_stat_r <= (irq_stat_r & ~irq_w1c) | irq_ev;
    end
  end
  assign irq = |(irq_stat_r & irq_mask_r);

  // Shared pin: open drain low on any alert flag in alert mode only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alert_or_charge_done_pin_oe_n <= 1'b1;
    end else if (ce) begin
      alert_or_charge_done_pin_oe_n <= !(alert_mode && (|flags_r[3:0]));
    end
  end
  assign alert_or_charge_done_pin_out = 1'b0;

  // Byte view for the serial slave
  function automatic logic [7:0] byte_at(input logic [2:0] p, input logic [7:0] st,
                                         input logic [7:0] ct, input logic [15:0] ch,
                                         input logic [15:0] th, input logic [15:0] tl);
    case (p)
      3'h0:    byte_at = st;
      3'h1:    byte_at = ct;
      3'h2:    byte_at = ch[15:8];
      3'h3:    byte_at = ch[7:0];
      3'h4:    byte_at = th[15:8];
      3'h5:    byte_at = th[7:0];
      3'h6:    byte_at = tl[15:8];
      default: byte_at = tl[7:0];
    endcase
  endfunction : byte_at

  // Next byte the slave shifts out
  logic [7:0] ser_next_byte;
  assign ser_next_byte = byte_at(ptr_r, status_byte, control_r, charge_r, thr_high_r, thr_low_r);

  // Serial bus edges; clock is sampled at 100 MHz, ample for 400 kHz
  logic scl_rise, scl_fall, ser_start, ser_stop;
  assign scl_rise  = scl_q && !scl_d_r;
  assign scl_fall  = !scl_q && scl_d_r;
  assign ser_start = scl_q && scl_d_r && sda_d_r && !sda_q;
  assign ser_stop  = scl_q && scl_d_r && !sda_d_r && sda_q;

  // Serial slave: address, pointer byte, data bytes with auto-increment
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ser_r      <= SER_IDLE;
      bit_cnt_r  <= 4'h0;
      shift_r    <= 8'h00;
      ptr_r      <= 3'h0;
      ptr_done_r <= 1'b0;
      rw_r       <= 1'b0;
      sda_oe_n   <= 1'b1;
    end else if (ce) begin
      if (ser_start) begin
        ser_r     <= SER_ADDR;
        bit_cnt_r <= 4'h0;
        sda_oe_n  <= 1'b1;
      end else if (ser_stop) begin
        ser_r    <= SER_IDLE;
        sda_oe_n <= 1'b1;
      end else begin
        case (ser_r)
          SER_ADDR, SER_WR: begin
            if (scl_rise) begin
              shift_r   <= {shift_r[6:0], sda_q};
              bit_cnt_r <= 4'(bit_cnt_r + 4'h1);
            end else if (scl_fall && bit_cnt_r == 4'h8) begin
              bit_cnt_r <= 4'h0;
              if (ser_r == SER_ADDR) begin
                if (shift_r[7:1] == gauge_pkg::SERIAL_ADDR) begin
                  rw_r       <= shift_r[0];
                  ptr_done_r <= 1'b0;
                  sda_oe_n   <= 1'b0;
                  ser_r      <= SER_ACK_A;
                end else begin
                  ser_r <= SER_IDLE;
                end
              end else begin
                if (!ptr_done_r) ptr_r <= shift_r[2:0];
                ptr_done_r <= 1'b1;
                sda_oe_n   <= 1'b0;
                ser_r      <= SER_ACK_W;
              end
            end
          end
          SER_ACK_A, SER_ACK_W: begin
            if (scl_fall) begin
              if (ser_r == SER_ACK_A && rw_r) begin
                shift_r  <= ser_next_byte;
                sda_oe_n <= ser_next_byte[7];
                bit_cnt_r <= 4'h1;
                ser_r    <= SER_RD;
              end else begin
                sda_oe_n <= 1'b1;
                ser_r    <= SER_WR;
                if (ser_wr) ptr_r <= 3'(ptr_r + 3'h1);  // Advance on each data byte, not on the pointer byte
              end
            end
          end
          SER_RD: begin
            if (scl_fall) begin
              if (bit_cnt_r == 4'h8) begin
                sda_oe_n <= 1'b1;
                ptr_r    <= 3'(ptr_r + 3'h1);
                ser_r    <= SER_ACK_R;
              end else begin
                sda_oe_n  <= shift_r[6];
                shift_r   <= {shift_r[6:0], 1'b0};
                bit_cnt_r <= 4'(bit_cnt_r + 4'h1);
              end
            end
          end
          SER_ACK_R: begin
            if (scl_rise && sda_q) begin
              ser_r <= SER_IDLE;
            end else if (scl_fall) begin
              shift_r   <= ser_next_byte;
              sda_oe_n  <= ser_next_byte[7];
              bit_cnt_r <= 4'h1;
              ser_r     <= SER_RD;
            end
          end
          default: ser_r <= SER_IDLE;
        endcase
      end
    end
  end
  assign sda_out       = 1'b0;
  assign ser_wr        = (ser_r == SER_ACK_W) && scl_fall && ptr_done_r && !ser_start && !ser_stop
                         && (bit_cnt_r == 4'h0) && wr_data_ok;
  assign ser_wbyte     = shift_r;
  assign ser_wptr      = ptr_r;
  assign ser_rd_status = (ser_r == SER_RD) && scl_fall && (bit_cnt_r == 4'h8) && (ptr_r == 3'h0);

  // Pointer byte is not a data write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_data_ok_r <= 1'b0;
    end else if (ce) begin
      if (ser_r == SER_ADDR) wr_data_ok_r <= 1'b0;
      else if (ser_r == SER_ACK_W && scl_fall) wr_data_ok_r <= 1'b1;
    end
  end
  assign wr_data_ok = wr_data_ok_r;

  // AXI write address and data held until both are present
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
  assign axi_wr = aw_held_r && w_held_r && !s_axi_bvalid;
  assign axi_wa = aw_addr_r;
  assign axi_wd = w_data_r;
  assign axi_ws = w_strb_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r    <= 1'b0;
      w_held_r     <= 1'b0;
      aw_addr_r    <= 8'h00;
      w_data_r     <= 32'h0000_0000;
      w_strb_r     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= gauge_pkg::AXI_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (axi_wr) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_r == gauge_pkg::OFS_STATUS || aw_addr_r > gauge_pkg::OFS_IRQ_MASK
                         || aw_addr_r[1:0] != 2'b00) ? gauge_pkg::AXI_SLVERR : gauge_pkg::AXI_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI read: one cycle to data, status read clears gone flags
  assign s_axi_arready = !s_axi_rvalid;
  assign axi_rd_status = s_axi_arvalid && s_axi_arready && s_axi_araddr == gauge_pkg::OFS_STATUS;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= gauge_pkg::AXI_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= gauge_pkg::AXI_OKAY;
        case (s_axi_araddr)
          gauge_pkg::OFS_STATUS:   s_axi_rdata <= {24'h00_0000, status_byte};
          gauge_pkg::OFS_CONTROL:  s_axi_rdata <= {24'h00_0000, control_r};
          gauge_pkg::OFS_CHARGE:   s_axi_rdata <= {16'h0000, charge_r};
          gauge_pkg::OFS_THR_HIGH: s_axi_rdata <= {16'h0000, thr_high_r};
          gauge_pkg::OFS_THR_LOW:  s_axi_rdata <= {16'h0000, thr_low_r};
          gauge_pkg::OFS_IRQ_STAT: s_axi_rdata <= {27'h000_0000, irq_stat_r};
          gauge_pkg::OFS_IRQ_MASK: s_axi_rdata <= {27'h000_0000, irq_mask_r};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= gauge_pkg::AXI_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : gauge_pin_top

// [verif/gauge_pin_top_props.sv]
// Checker: bus handshakes, pin drive and reset state of the gauge block.
// Assumes a bind to gauge_pin_top, one clock domain.
`timescale 1ns/1ps
module gauge_pin_top_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic sda_out,
  input wire logic alert_or_charge_done_pin_out,
  input wire logic alert_or_charge_done_pin_oe_n,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Register bus answers and refusals
  a_bv_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped early");
  a_bv_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  a_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  // Open-drain pins only ever pull low
  a_pin_open: assert property (!alert_or_charge_done_pin_out)
    else $error("shared pin driven high");
  a_sda_open: assert property (!sda_out)
    else $error("data line driven high");
  a_rst_quiet: assert property (disable iff (1'b0) !aresetn |=> alert_or_charge_done_pin_oe_n && !irq)
    else $error("pin or irq active after reset");
endmodule : gauge_pin_top_props

bind gauge_pin_top gauge_pin_top_props props_i (.*);

// [verif/charger_model.sv]
// Charger model: holds the charge-done level high for a set stretch.
// Assumes the bench puts its level on the shared pin while attached.
`timescale 1ns/1ps
module charger_model #(parameter int HIGH_CYC = 120) (
  input wire logic aclk,
  input wire logic go,
  output logic     level
);
  int left = 0;
  // Reload on request, then count down to idle low
  always_ff @(posedge aclk) left <= go ? HIGH_CYC : left - int'(left > 0);
  assign level = (left > 0);
endmodule : charger_model

// [verif/tb_gauge_alert_charge_done_pin.sv]
// Bench: AXI register accesses with ramp, alert, irq and charge-done scenarios.
// Assumes the checker and the charger model are compiled first.
`timescale 1ns/1ps
module tb_gauge_alert_charge_done_pin;
  logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, arv = 0, brdy = 0, rrdy = 0;
  logic        flip = 0, up = 0, b28 = 0, b29 = 0, b30 = 0, uv = 0, go = 0, att = 0;
  logic        scl = 1, sda_h = 1;
  logic        awr, wrdy, bv, arr, rv, oe_n, irq, cc, soe;
  logic [7:0]  awa = 0, ara = 0;
  logic [31:0] wd = 0, rd;
  logic [1:0]  rresp, bresp;
  int          fails = 0, samples_checked = 0, cyc = 0;
  wire         pin = !oe_n ? 1'b0 : (att ? cc : 1'b1); // Pulled up when idle
  wire         sda = sda_h & soe; // Open-drain data line, pulled up
  gauge_pin_top dut (.aclk, .aresetn, .ce(1'b1), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brdy),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrdy), .ramp_flip(flip),
    .ramp_up(up), .vbat_below_2v8(b28), .vbat_below_2v9(b29), .vbat_below_3v0(b30),
    .uvlo_seen(uv), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe_n(soe),
    .alert_or_charge_done_pin_in(pin), .alert_or_charge_done_pin_out(),
    .alert_or_charge_done_pin_oe_n(oe_n), .irq);
  charger_model #(.HIGH_CYC(120)) partner (.aclk, .go, .level(cc));
  initial forever #5 aclk = ~aclk;
  // Cycle ceiling cuts a hang short
  always @(posedge aclk) if (++cyc == 12000) begin fails++; final_report(); end
  task automatic chk(input string nm, input logic [33:0] exp, got);
    samples_checked++;
    if (got !== exp) begin fails++; $display("BAD %s exp %h got %h", nm, exp, got); end
  endtask : chk
  // One AXI access; reads compare data under a mask and the response code
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, m = '1);
    logic [1:0] er;
    er = (a > 8'h18 || (w && a == 8'h00)) ? 2'h2 : 2'h0;
    if (w) begin awa <= a; wd <= d; awv <= 1; wv <= 1; brdy <= 1; end
    else begin ara <= a; arv <= 1; rrdy <= 1; end
    do begin @(posedge aclk); if (awr) awv <= 0; if (wrdy) wv <= 0; if (arr) arv <= 0; end
    while (!(w ? bv : rv));
    if (!w) chk("read", {er, d}, {rresp, rd & m});
    if (w) chk("bresp", er, bresp);
    brdy <= 0; rrdy <= 0; @(posedge aclk);
  endtask : acc
  // Ramp reversals in one direction
  task automatic ramp(input int n, input logic d);
    up <= d;
    repeat (n) begin flip <= 1; repeat (4) @(posedge aclk); flip <= 0; repeat (4) @(posedge aclk); end
    repeat (4) @(posedge aclk);
  endtask : ramp
  // Serial byte: eight bits and a released acknowledge slot, 400 kHz clock
  task automatic ser_byte(input logic [8:0] b);
    for (int i = 8; i >= 0; i--) begin
      sda_h <= b[i];
      repeat (62) @(posedge aclk);
      scl <= 1;
      repeat (125) @(posedge aclk);
      if (i == 0) chk("ser_ack", 0, sda);
      scl <= 0;
      repeat (63) @(posedge aclk);
    end
  endtask : ser_byte
  // Serial write of one data byte behind a pointer byte, framed by start and stop
  task automatic ser_write(input logic [7:0] p, input logic [7:0] d);
    sda_h <= 0;
    repeat (63) @(posedge aclk);
    scl <= 0;
    repeat (63) @(posedge aclk);
    ser_byte({gauge_pkg::SERIAL_ADDR, 2'b01});
    ser_byte({p, 1'b1});
    ser_byte({d, 1'b1});
    sda_h <= 0;
    repeat (63) @(posedge aclk);
    scl <= 1;
    repeat (63) @(posedge aclk);
    sda_h <= 1;
    repeat (63) @(posedge aclk);
  endtask : ser_write
  task automatic final_report();
    $display("Checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report
  // Scenarios in order after reset
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    chk("pin_oe_n", 1, oe_n);
    acc(0, 8'h04, 32'h3C);
    acc(0, 8'h00, 32'h80);
    acc(0, 8'h40, 32'h0);
    acc(1, 8'h00, 32'hFF);
    acc(1, 8'h04, 32'h04);
    ramp(3, 1);
    acc(0, 8'h08, 32'h8002);
    acc(1, 8'h04, 32'h0C);
    ramp(2, 1);
    acc(0, 8'h08, 32'h8003);
    acc(1, 8'h04, 32'h04);
    acc(1, 8'h08, 32'hFFFE);
    acc(1, 8'h0C, 32'h8000);
    ramp(3, 1);
    acc(0, 8'h08, 32'hFFFF);
    chk("pin_oe_n", 0, oe_n);
    acc(0, 8'h00, 32'hA8);
    chk("irq", 0, irq);
    acc(1, 8'h18, 32'h1);
    chk("irq", 1, irq);
    acc(1, 8'h14, 32'h1);
    chk("irq", 0, irq);
    ramp(1, 0);
    acc(0, 8'h08, 32'hFFFE);
    att <= 1;
    acc(1, 8'h04, 32'h02);
    acc(1, 8'h08, 32'h1234);
    chk("pin_oe_n", 1, oe_n);
    go <= 1;
    @(posedge aclk);
    go <= 0;
    repeat (130) @(posedge aclk);
    acc(0, 8'h08, 32'hFFFF);
    b30 <= 1;
    for (int c = 1; c < 4; c++) begin
      acc(1, 8'h04, 32'(c << 6 | 2));
      acc(0, 8'h00, {30'h0, c == 3, 1'b0}, 32'h2);
    end
    uv <= 1;
    repeat (4) @(posedge aclk);
    acc(0, 8'h00, 32'h1, 32'h1);
    uv <= 0;
    repeat (4) @(posedge aclk);
    acc(0, 8'h00, 32'h1, 32'h1);
    acc(0, 8'h00, 32'h0, 32'h1);
    ser_write(8'h01, 8'h7C);
    acc(0, 8'h04, 32'h7C);
    final_report();
  end
endmodule : tb_gauge_alert_charge_done_pin
